/* rtl/rx_datalink_alarm_and_message_receiver.sv */
// Receive data-link controller: alarm code receiver and message receiver with buffer.
// Assumes alarm and data-link bits arrive as one-cycle strobes from the frame aligner
// on the same clock, and a single AHB-Lite master with this slave as the only one.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Alarm code bits are taken only while C-bit parity framing is selected.
// - Alarm message: eight ones, zero, d0..d5, zero; ones end arrives first.
// - One alarm bit per frame; sixteen frames make one message.
// - Message boundary found by eight ones then two zeros with six bits between them.
// - Code seen in eight of last ten messages is validated and stored.
// - Validation sets the validated bit and valid event status, raising interrupt.
// - Code register holds last validated code in bits 6..1, others zero.
// - Three of last ten differing from validated code removes it, with interrupt.
// - Removal clears the validated bit, bit 4 of the alarm interrupt register.
// - Alarm interrupt register: enables bits 1 and 3, status bits clear on read.
// - Message bits come from the three data-link overhead bits per multiframe.
// - Enabled message receiver hunts for 0x7e flag octets.
// - Inserted zeros between opening and closing flags are discarded.
// - Frame: flag, 0x3c/0x3e, 0x01, 0x03, information, check MSB first, flag.
// - Check sequence verified with CRC-16 x16+x12+x5+1 over de-stuffed data.
// - First information octet decodes message type.
// - Message stored in buffer at locations 0xde to 0x135.
// - Status: end, flag, abort, type, command/response bit, check error.
// - Alarm codes and message frames are received concurrently.
// - A zero following five consecutive ones is deleted.
// - Check error bit set on mismatch, zero otherwise.
// - End-of-message bit set when the closing flag arrives.
module rx_datalink_alarm_and_message_receiver
  import rx_dl_pkg::*;
#(
  parameter logic [15:0] CRC_INIT = CRC_INIT_DEFAULT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Overhead bits from the frame aligner
  input  wire logic        c_bit_mode,
  input  wire logic        alarm_bit,
  input  wire logic        alarm_bit_valid,
  input  wire logic        datalink_overhead_bits,
  input  wire logic        datalink_bit_valid,
  // Interrupt request
  output logic             irq
);

  typedef enum logic {HUNT, RECV} lapd_state_t;

  // ---------------- Bus slave ----------------
  wire             bus_take = hsel && htrans[1] && hready && (hsize == 3'b010);
  wire [8:0]       bus_idx  = haddr[10:2];
  wire             bus_rd   = bus_take && !hwrite;
  logic            wr_pend;
  logic [8:0]      wr_idx;
  wire             wr_airq  = wr_pend && (wr_idx == IDX_ALARM_IRQ);
  wire             wr_lctrl = wr_pend && (wr_idx == IDX_LAPD_CTRL);
  wire             rd_airq  = bus_rd && (bus_idx == IDX_ALARM_IRQ);
  wire             rd_lctrl = bus_rd && (bus_idx == IDX_LAPD_CTRL);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= 9'h000;
    end else begin
      wr_pend <= bus_take && hwrite;
      wr_idx  <= bus_idx;
    end
  end

  // ---------------- Alarm code receiver ----------------
  logic [ALARM_MSG_BITS-1:0] alarm_sr;
  logic [5:0]                hist [ALARM_HIST];
  logic [ALARM_HIST-1:0]     hist_vld;
  logic                      hist_new;
  logic [5:0]                alarm_code;
  logic                      validated;
  logic                      valid_stat;
  logic                      valid_en;
  logic                      remove_stat;
  logic                      remove_en;
  logic [3:0]                eq_cnt;
  logic [3:0]                diff_cnt;

  wire        alarm_take = alarm_bit_valid && c_bit_mode;
  wire [15:0] next_alarm_sr = {alarm_bit, alarm_sr[15:1]};
  wire        alarm_framed = alarm_take && (next_alarm_sr[7:0] == 8'hff)
                             && !next_alarm_sr[8] && !next_alarm_sr[15];
  wire        validate_evt = hist_new && !validated && (eq_cnt >= ALARM_VALID_MIN);
  wire        remove_evt   = hist_new && validated && (diff_cnt >= ALARM_REMOVE_MIN);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_sr <= '0;
    end else if (alarm_framed) begin
      alarm_sr <= '0;
    end else if (alarm_take) begin
      alarm_sr <= next_alarm_sr;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hist_vld <= '0;
      hist_new <= 1'b0;
      for (int i = 0; i < ALARM_HIST; i++) hist[i] <= 6'h00;
    end else begin
      hist_new <= alarm_framed;
      if (alarm_framed) begin
        hist[0]  <= next_alarm_sr[14:9];
        hist_vld <= {hist_vld[ALARM_HIST-2:0], 1'b1};
        for (int i = 1; i < ALARM_HIST; i++) hist[i] <= hist[i-1];
      end
    end
  end

  always_comb begin
    eq_cnt   = 4'h0;
    diff_cnt = 4'h0;
    for (int i = 0; i < ALARM_HIST; i++) begin
      if (hist_vld[i] && (hist[i] == hist[0])) eq_cnt = eq_cnt + 4'h1;
      if (hist_vld[i] && (hist[i] != alarm_code)) diff_cnt = diff_cnt + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_code  <= 6'h00;
      validated   <= 1'b0;
      valid_stat  <= 1'b0;
      remove_stat <= 1'b0;
      valid_en    <= AIRQ_EN_RESET;
      remove_en   <= AIRQ_EN_RESET;
    end else begin
      if (validate_evt) alarm_code <= hist[0];
      validated   <= validate_evt || (validated && !remove_evt);
      valid_stat  <= validate_evt || (valid_stat && !rd_airq);
      remove_stat <= remove_evt || (remove_stat && !rd_airq);
      if (wr_airq) begin
        valid_en  <= hwdata[AIRQ_VALID_EN];
        remove_en <= hwdata[AIRQ_REMOVE_EN];
      end
    end
  end

  wire alarm_irq = (valid_stat && valid_en) || (remove_stat && remove_en);

  // ---------------- Message receiver ----------------
  lapd_state_t    state;
  lapd_status_t   status;
  logic           lapd_en;
  logic           lapd_ien;
  logic           lapd_istat;
  logic [2:0]     ones;
  logic [2:0]     bitcnt;
  logic [6:0]     ocount;
  logic [7:0]     octet;
  logic [7:0]     fcs_hi;
  logic [7:0]     fcs_lo;
  logic [15:0]    crc;
  logic [7:0]     buf_mem [BUF_DEPTH];
  logic [1:0]     next_type;

  function automatic logic [15:0] crc_octet(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      r = (r[15] ^ d[k]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_octet

  wire       lapd_bit   = datalink_bit_valid && lapd_en;
  wire       bit_in     = datalink_overhead_bits;
  wire       in_frame   = (state == RECV);
  wire       flag_hit   = lapd_bit && !bit_in && (ones == FLAG_RUN);
  wire       abort_hit  = lapd_bit && bit_in && (ones == FLAG_RUN) && in_frame;
  wire       stuff_drop = !bit_in && (ones == STUFF_RUN);
  wire       data_bit   = lapd_bit && in_frame && !flag_hit && !abort_hit && !stuff_drop;
  wire       octet_done = data_bit && (bitcnt == 3'd7);
  wire [7:0] next_octet = {bit_in, octet[7:1]};
  wire       close_evt  = flag_hit && in_frame && (bitcnt == 3'd7) && (ocount >= MIN_OCTETS);
  wire       hdr_bad    = octet_done && (
                            ((ocount == 7'd0) && (next_octet != ADDR1_CUST)
                             && (next_octet != ADDR1_NET))
                            || ((ocount == 7'd1) && (next_octet != ADDR2_OCTET))
                            || ((ocount == 7'd2) && (next_octet != CTRL_OCTET)));
  wire       hdr_ok     = octet_done && (ocount == 7'd2) && (next_octet == CTRL_OCTET);
  wire       overlong   = octet_done && (ocount == 7'(BUF_DEPTH - 1));
  wire       go_hunt    = !lapd_en || abort_hit || hdr_bad || overlong;
  wire       fcs_bad    = crc != {fcs_hi, fcs_lo};

  assign next_type = (next_octet == TYPE_CL_PATH)  ? 2'b00 :
                     (next_octet == TYPE_IDLE_SIG) ? 2'b01 :
                     (next_octet == TYPE_TEST_SIG) ? 2'b10 :
                     (next_octet == TYPE_ITU_PATH) ? 2'b11 : status.msg_type;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lapd_en  <= LCTRL_EN_RESET;
      lapd_ien <= LCTRL_IEN_RESET;
    end else if (wr_lctrl) begin
      lapd_en  <= hwdata[LCTRL_ENABLE];
      lapd_ien <= hwdata[LCTRL_IRQ_EN];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= HUNT;
      ones  <= 3'd0;
    end else begin
      if (lapd_bit) ones <= !bit_in ? 3'd0 : ((ones == 3'd7) ? ones : ones + 3'd1);
      if (go_hunt) state <= HUNT;
      else if (flag_hit) state <= RECV;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt <= 3'd0;
      ocount <= 7'd0;
      octet  <= 8'h00;
      fcs_hi <= 8'h00;
      fcs_lo <= 8'h00;
      crc    <= CRC_INIT;
    end else if (flag_hit) begin
      bitcnt <= 3'd0;
      ocount <= 7'd0;
      crc    <= CRC_INIT;
    end else if (data_bit) begin
      bitcnt <= bitcnt + 3'd1;
      octet  <= next_octet;
      if (octet_done) begin
        ocount <= ocount + 7'd1;
        fcs_lo <= next_octet;
        fcs_hi <= fcs_lo;
        if (ocount >= 7'd2) crc <= crc_octet(crc, fcs_hi);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (octet_done && !overlong) buf_mem[ocount + 7'd1] <= next_octet;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status     <= '0;
      lapd_istat <= 1'b0;
    end else begin
      status.flag <= flag_hit || (status.flag && !octet_done);
      if (close_evt) begin
        status.message_end_flag     <= 1'b1;
        status.fcs_err <= fcs_bad;
      end else if (hdr_ok) begin
        status.message_end_flag <= 1'b0;
      end
      status.abort <= abort_hit || (status.abort && !hdr_ok);
      if (octet_done && (ocount == 7'd0)) status.cr <= next_octet[1];
      if (octet_done && (ocount == 7'd3)) status.msg_type <= next_type;
      lapd_istat <= close_evt || (lapd_istat && !rd_lctrl);
    end
  end

  // ---------------- Read path and interrupt ----------------
  wire       in_buf   = (bus_idx >= IDX_BUF_FIRST) && (bus_idx <= IDX_BUF_LAST);
  wire [6:0] buf_ofs  = 7'(bus_idx - IDX_BUF_FIRST);
  wire [7:0] buf_rd   = (buf_ofs == 7'd0) ? FLAG_OCTET : buf_mem[buf_ofs];
  wire [7:0] airq_rd  = {3'b000, validated, remove_en, remove_stat, valid_en, valid_stat};
  wire [7:0] lctrl_rd = {5'b00000, lapd_en, lapd_ien, lapd_istat};
  wire [7:0] rd_byte  = (bus_idx == IDX_ALARM_CODE) ? {1'b0, alarm_code, 1'b0} :
                        (bus_idx == IDX_ALARM_IRQ)  ? airq_rd :
                        (bus_idx == IDX_LAPD_CTRL)  ? lctrl_rd :
                        (bus_idx == IDX_LAPD_STAT)  ? {1'b0, status} :
                        in_buf                      ? buf_rd : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      irq    <= 1'b0;
    end else begin
      if (bus_rd) hrdata <= {24'h000000, rd_byte};
      irq <= alarm_irq || (lapd_istat && lapd_ien);
    end
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  mode_gate_a: assert property (alarm_bit_valid && !c_bit_mode |=> $stable(alarm_sr))
    else $error("alarm shift register moved outside C-bit parity mode");
  history_push_a: assert property (alarm_framed |=> hist_new && hist_vld[0]
                                   && hist[0] == $past(next_alarm_sr[14:9]))
    else $error("framed alarm message not pushed into history");
  code_validate_a: assert property (validate_evt |=> validated && valid_stat
                                    && alarm_code == $past(hist[0]))
    else $error("validation did not store code and set status");
  code_remove_a: assert property (remove_evt |=> !validated && remove_stat)
    else $error("removal did not clear validated bit");
  status_clear_a: assert property (rd_airq && !validate_evt && !remove_evt
                                   |=> !valid_stat && !remove_stat)
    else $error("alarm status not cleared by read");
  irq_gate_a: assert property (irq |-> $past(alarm_irq) || $past(lapd_istat && lapd_ien))
    else $error("interrupt raised without enabled status");
  stuff_drop_a: assert property (lapd_bit && in_frame && stuff_drop && !flag_hit
                                 |=> $stable(bitcnt) && $stable(octet))
    else $error("stuffed zero was not dropped");
  flag_seen_a: assert property (flag_hit |=> status.flag && state == RECV)
    else $error("flag octet not reported");
  end_mark_a: assert property (close_evt |=> status.message_end_flag
                               && status.fcs_err == $past(fcs_bad))
    else $error("closing flag did not update end and check status");

endmodule : rx_datalink_alarm_and_message_receiver

`default_nettype wire

/* shared/rx_dl_pkg.sv */
// Constants, register map and status layout of the receive data-link controller.
// Assumes a 32-bit AHB-Lite register bus whose word index is haddr[10:2].
package rx_dl_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [8:0]  IDX_ALARM_CODE   = 9'h016;
  localparam logic [8:0]  IDX_ALARM_IRQ    = 9'h017;
  localparam logic [8:0]  IDX_LAPD_CTRL    = 9'h018;
  localparam logic [8:0]  IDX_LAPD_STAT    = 9'h019;
  localparam logic [8:0]  IDX_BUF_FIRST    = 9'h0de;
  localparam logic [8:0]  IDX_BUF_LAST     = 9'h135;

  // Alarm interrupt enable/status fields
  localparam int          AIRQ_VALID_STAT  = 0;
  localparam int          AIRQ_VALID_EN    = 1;
  localparam int          AIRQ_REMOVE_STAT = 2;
  localparam int          AIRQ_REMOVE_EN   = 3;
  localparam int          AIRQ_VALIDATED   = 4;
  localparam logic        AIRQ_EN_RESET    = 1'b0;

  // Message receiver control fields
  localparam int          LCTRL_IRQ_STAT   = 0;
  localparam int          LCTRL_IRQ_EN     = 1;
  localparam int          LCTRL_ENABLE     = 2;
  localparam logic        LCTRL_EN_RESET   = 1'b1;
  localparam logic        LCTRL_IEN_RESET  = 1'b0;

  // Alarm code message
  localparam int          ALARM_MSG_BITS   = 16;
  localparam int          ALARM_HIST       = 10;
  localparam logic [3:0]  ALARM_VALID_MIN  = 4'd8;
  localparam logic [3:0]  ALARM_REMOVE_MIN = 4'd3;

  // Message framing
  localparam logic [7:0]  FLAG_OCTET       = 8'h7e;
  localparam logic [7:0]  ADDR1_CUST       = 8'h3c;
  localparam logic [7:0]  ADDR1_NET        = 8'h3e;
  localparam logic [7:0]  ADDR2_OCTET      = 8'h01;
  localparam logic [7:0]  CTRL_OCTET       = 8'h03;
  localparam logic [7:0]  TYPE_CL_PATH     = 8'h38;
  localparam logic [7:0]  TYPE_IDLE_SIG    = 8'h34;
  localparam logic [7:0]  TYPE_TEST_SIG    = 8'h32;
  localparam logic [7:0]  TYPE_ITU_PATH    = 8'h3f;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEFAULT = 16'hffff;
  localparam logic [2:0]  STUFF_RUN        = 3'd5;
  localparam logic [2:0]  FLAG_RUN         = 3'd6;
  localparam logic [6:0]  MIN_OCTETS       = 7'd5;
  localparam int          BUF_DEPTH        = 88;

  typedef struct packed {
    logic       abort;
    logic [1:0] msg_type;
    logic       cr;
    logic       fcs_err;
    logic       message_end_flag;
    logic       flag;
  } lapd_status_t;

endpackage : rx_dl_pkg

/* tb/overhead_source.sv */
// Stand-in for the frame aligner: feeds alarm-code bits and data-link bits.
// Assumes callers enter its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module overhead_source (
  // Clock
  input  wire logic clock,
  // Alarm-code overhead channel
  output logic      alarm_bit,
  output logic      alarm_bit_valid,
  // Data-link overhead channel
  output logic      datalink_overhead_bits,
  output logic      datalink_bit_valid
);
  int ones;

  initial begin
    alarm_bit              = 1'b0;
    alarm_bit_valid        = 1'b0;
    datalink_overhead_bits = 1'b0;
    datalink_bit_valid     = 1'b0;
    ones                   = 0;
  end

  // Between strobes the line shows the inverse of the last bit, never a stale copy
  task automatic put_alarm(input logic b);
    alarm_bit       <= b;
    alarm_bit_valid <= 1'b1;
    @(posedge clock);
    alarm_bit       <= ~b;
    alarm_bit_valid <= 1'b0;
    @(posedge clock);
  endtask : put_alarm

  task automatic put_dl(input logic b);
    datalink_overhead_bits <= b;
    datalink_bit_valid     <= 1'b1;
    @(posedge clock);
    datalink_overhead_bits <= ~b;
    datalink_bit_valid     <= 1'b0;
    @(posedge clock);
  endtask : put_dl

  // Same message repeated, ones end first, one bit per frame
  task automatic send_alarm(input logic [5:0] code, input int reps);
    logic [15:0] msg;
    msg = {1'b0, code, 1'b0, 8'hff};
    repeat (reps) begin
      for (int i = 0; i < 16; i++) begin
        put_alarm(msg[i]);
      end
    end
  endtask : send_alarm

  // Octet LSB first; when stuff is set a zero goes in after five ones
  task automatic send_octet(input logic [7:0] o, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      put_dl(o[i]);
      ones = (stuff && o[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        put_dl(1'b0);
        ones = 0;
      end
    end
  endtask : send_octet
endmodule : overhead_source
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the receive data-link controller.
// Assumes the overhead source model stands in for the frame aligner.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rx_dl_pkg::*;
;
  localparam int LIMIT = 20000;
  logic        clock;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        c_bit_mode;
  logic        alarm_bit;
  logic        alarm_bit_valid;
  logic        dl_bit;
  logic        dl_valid;
  logic        irq;
  logic [31:0] rd;
  int          fails;
  int          compares;

  rx_datalink_alarm_and_message_receiver #(.CRC_INIT(CRC_INIT_DEFAULT)) uut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .c_bit_mode(c_bit_mode),
    .alarm_bit(alarm_bit), .alarm_bit_valid(alarm_bit_valid),
    .datalink_overhead_bits(dl_bit), .datalink_bit_valid(dl_valid), .irq(irq));

  overhead_source src (
    .clock(clock), .alarm_bit(alarm_bit), .alarm_bit_valid(alarm_bit_valid),
    .datalink_overhead_bits(dl_bit), .datalink_bit_valid(dl_valid));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
    haddr  <= {21'h00000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : bus

  task automatic expect_reg(input logic [8:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h00000000);
    check(rd, exp);
  endtask : expect_reg

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] o);
    for (int i = 0; i < 8; i++) begin
      c = (c << 1) ^ ((c[15] ^ o[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : crc_step

  task automatic send_frame(input logic [7:0] a1, input logic [7:0] ty, input logic bad);
    logic [7:0]  body [6];
    logic [15:0] crc;
    body = '{a1, ADDR2_OCTET, CTRL_OCTET, ty, 8'hff, 8'h55};
    crc = CRC_INIT_DEFAULT;
    src.send_octet(FLAG_OCTET, 1'b0);
    foreach (body[i]) begin
      crc = crc_step(crc, body[i]);
      src.send_octet(body[i], 1'b1);
    end
    crc[0] = crc[0] ^ bad;
    src.send_octet(crc[15:8], 1'b1);
    src.send_octet(crc[7:0], 1'b1);
    src.send_octet(FLAG_OCTET, 1'b0);
    idle(4);
  endtask : send_frame

  task automatic reset_values();
    expect_reg(IDX_ALARM_CODE, 32'h00000000);
    expect_reg(IDX_ALARM_IRQ, 32'h00000000);
    expect_reg(IDX_LAPD_CTRL, 32'h00000004);
    expect_reg(IDX_LAPD_STAT, 32'h00000000);
    expect_reg(9'h136, 32'h00000000);
  endtask : reset_values

  task automatic alarm_codes();
    bus(1'b1, IDX_ALARM_IRQ, 32'h0000000a);
    src.send_alarm(6'h25, 10);
    idle(6);
    expect_reg(IDX_ALARM_IRQ, 32'h0000000a);
    c_bit_mode <= 1'b1;
    src.send_alarm(6'h25, 7);
    idle(6);
    expect_reg(IDX_ALARM_IRQ, 32'h0000000a);
    src.send_alarm(6'h25, 3);
    idle(6);
    check({31'h0, irq}, 32'h00000001);
    expect_reg(IDX_ALARM_CODE, 32'h0000004a);
    expect_reg(IDX_ALARM_IRQ, 32'h0000001b);
    expect_reg(IDX_ALARM_IRQ, 32'h0000001a);
    idle(3);
    check({31'h0, irq}, 32'h00000000);
    src.send_alarm(6'h12, 2);
    idle(6);
    expect_reg(IDX_ALARM_IRQ, 32'h0000001a);
    src.send_alarm(6'h12, 1);
    idle(6);
    expect_reg(IDX_ALARM_IRQ, 32'h0000000e);
    expect_reg(IDX_ALARM_CODE, 32'h0000004a);
  endtask : alarm_codes

  task automatic message_frames();
    logic [7:0] types [4];
    logic [7:0] a1;
    types = '{TYPE_CL_PATH, TYPE_IDLE_SIG, TYPE_TEST_SIG, TYPE_ITU_PATH};
    bus(1'b1, IDX_LAPD_CTRL, 32'h00000002);
    send_frame(ADDR1_CUST, TYPE_CL_PATH, 1'b0);
    expect_reg(IDX_LAPD_STAT, 32'h00000000);
    bus(1'b1, IDX_LAPD_CTRL, 32'h00000006);
    for (int t = 0; t < 4; t++) begin
      a1 = t[0] ? ADDR1_NET : ADDR1_CUST;
      send_frame(a1, types[t], t == 2);
      check({31'h0, irq}, 32'h00000001);
      expect_reg(IDX_LAPD_STAT, {25'h0, 1'b0, t[1:0], a1[1], t == 2, 2'b11});
      expect_reg(IDX_LAPD_CTRL, 32'h00000007);
      if (t != 2) begin
        expect_reg(IDX_BUF_FIRST, {24'h000000, FLAG_OCTET});
        expect_reg(9'h0df, {24'h000000, a1});
        expect_reg(9'h0e2, {24'h000000, types[t]});
        expect_reg(9'h0e3, 32'h000000ff);
      end
    end
  endtask : message_frames

  // Abort inside a frame, then an alarm code and a frame arriving together
  task automatic mixed_traffic();
    src.send_octet(FLAG_OCTET, 1'b0);
    src.send_octet(ADDR1_CUST, 1'b1);
    src.send_octet(8'hff, 1'b0);
    idle(4);
    expect_reg(IDX_LAPD_STAT, 32'h00000072);
    fork
      src.send_alarm(6'h12, 5);
      send_frame(ADDR1_NET, TYPE_ITU_PATH, 1'b0);
    join
    idle(6);
    expect_reg(IDX_ALARM_CODE, 32'h00000024);
    expect_reg(IDX_LAPD_STAT, 32'h0000003b);
  endtask : mixed_traffic

  initial begin
    rst_n      = 1'b0;
    hsel       = 1'b1;
    haddr      = 32'h00000000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h00000000;
    c_bit_mode = 1'b0;
    fails      = 0;
    compares   = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    fork
      begin
        reset_values();
        alarm_codes();
        message_frames();
        mixed_traffic();
      end
      begin
        repeat (LIMIT) @(posedge clock);
        fails++;
      end
    join_any
    close_out();
  end
endmodule : testbench
`default_nettype wire
